// [edmp_defines.svh]
`ifndef EDMP_DEFINES_SVH
`define EDMP_DEFINES_SVH

// Data bus and address widths
`define EDMP_ADDR_W 16
`define EDMP_DATA_W 16

// Space select encodings
`define EDMP_SPACE_X 1'b0
`define EDMP_SPACE_Y 1'b1

// Reset values
`define EDMP_ADDR_RST 16'h0000
`define EDMP_DATA_RST 16'h0000

// Default programmed wait cycles and counter width
`define EDMP_WAIT_W 4
`define EDMP_WAIT_DEF 4'h0

// Clock divide ratio of the cycle clock
`define EDMP_CLK_DIV 2

`endif

// [edmp_pkg.sv]
`default_nettype none
package edmp_pkg;
    // Access engine states, one-hot
    typedef enum logic [2:0] {
        st_idle = 3'h1,
        st_access = 3'h2,
        st_hold = 3'h4
    } edmp_state_t;
endpackage
`default_nettype wire

// [edmp_port.sv]
`timescale 1ns/100ps
`default_nettype none
`include "edmp_defines.svh"

// Functional notes
// (R1) Cycle clock output is the input clock halved, in phase with it.
// (R2) Reset initialises every piece of port state.
// (R3) Space select low chooses X space, high chooses Y space.
// (R4) Only one external access at a time, so X and Y never overlap.
// (R5) Address bus holds the last accessed address while idle.
// (R6) Address bus is all zero from reset until the first access.
// (R7) Sixteen-bit three-state data bus, driven on writes, sampled on reads.
// (R8) Each access inserts the programmed number of wait cycles.
// (R9) Wait input sampled after programmed waits; low adds one more cycle.
// (R10) Slow memory holds wait low until it can finish.
// (R11) External master drives hold request low to ask, high otherwise.
// (R12) Hold grant goes low once the external master may use the bus.
// (R13) Bus-in-use strobe low while this port uses the bus.
// (R14) During grant, bus outputs float and no access starts.
// (R15) Read and write strobes active low, exclusive, high when idle.
module edmp_port #(
    parameter int WAIT_W = `EDMP_WAIT_W
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Core request side
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic req_space_in,
    input wire logic [`EDMP_ADDR_W-1:0] req_addr_in,
    input wire logic [`EDMP_DATA_W-1:0] req_wdata_in,
    input wire logic [WAIT_W-1:0] wait_count_in,
    output logic req_ready_out,
    output logic rsp_valid_out,
    output logic [`EDMP_DATA_W-1:0] rsp_rdata_out,
    // Cycle clock
    output logic cycle_clock_out,
    // External memory bus
    output logic [`EDMP_ADDR_W-1:0] ext_addr_out,
    output logic ext_space_out,
    output logic mem_read_strobe_n_out,
    output logic mem_write_strobe_n_out,
    output logic ext_ctrl_oe_n_out,
    input wire logic [`EDMP_DATA_W-1:0] ext_data_in,
    output logic [`EDMP_DATA_W-1:0] ext_data_out,
    output logic ext_data_oe_n_out,
    input wire logic ext_wait_n_in,
    // Bus arbitration
    input wire logic bus_hold_request_n_in,
    output logic bus_hold_grant_n_out,
    output logic bus_in_use_strobe_n_out
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    edmp_pkg::edmp_state_t state_reg;
    logic phase_reg;
    logic cyc_en;
    logic [2:0] wait_sync_reg;
    logic wait_f_reg;
    logic [2:0] hold_sync_reg;
    logic hold_f_reg;
    logic [`EDMP_DATA_W-1:0] data_s1_reg;
    logic [`EDMP_DATA_W-1:0] data_s2_reg;
    logic [`EDMP_DATA_W-1:0] data_s3_reg;
    logic [WAIT_W-1:0] wait_cnt_reg;
    logic write_reg;
    logic [`EDMP_ADDR_W-1:0] addr_reg;
    logic space_reg;
    logic [`EDMP_DATA_W-1:0] wdata_reg;
    logic take;
    logic done;

    // Filtered level moves only when the last two stages agree
    function automatic logic edmp_agree(input logic s2, input logic s3, input logic old);
        edmp_agree = (s2 == s3) ? s3 : old;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Cycle clock divider

    // Toggle flop; rising edge of the cycle clock meets a clk_in rise
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            phase_reg <= 1'b0; // R2
        end else begin
            phase_reg <= ~phase_reg; // R1
        end
    end

    assign cycle_clock_out = phase_reg; // R1
    // One enable per instruction cycle; state and wait counter step on it, pin registers and synchronisers on every clk_in edge
    assign cyc_en = phase_reg;

    ////////////////////////////////////////////////////////////////////////
    // Pin input synchronisers

    // Wait input; stage 0 feeds only stage 1
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wait_sync_reg <= 3'h7;
            wait_f_reg <= 1'b1;
        end else begin
            wait_sync_reg <= {wait_sync_reg[1:0], ext_wait_n_in};
            wait_f_reg <= edmp_agree(wait_sync_reg[1], wait_sync_reg[2], wait_f_reg);
        end
    end

    // Hold request input
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            hold_sync_reg <= 3'h7;
            hold_f_reg <= 1'b1;
        end else begin
            hold_sync_reg <= {hold_sync_reg[1:0], bus_hold_request_n_in};
            hold_f_reg <= edmp_agree(hold_sync_reg[1], hold_sync_reg[2], hold_f_reg); // R11
        end
    end

    // Read data pipeline; memory must hold data stable until the read strobe rises
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            data_s1_reg <= `EDMP_DATA_RST;
            data_s2_reg <= `EDMP_DATA_RST;
            data_s3_reg <= `EDMP_DATA_RST;
        end else begin
            data_s1_reg <= ext_data_in;
            data_s2_reg <= data_s1_reg;
            data_s3_reg <= data_s2_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Access engine

    // Hold wins over a new request so a waiting master is not starved
    assign take = cyc_en && (state_reg == edmp_pkg::st_idle) && hold_f_reg && req_valid_in; // R14
    assign req_ready_out = cyc_en && (state_reg == edmp_pkg::st_idle) && hold_f_reg;
    // Finish only after programmed waits and wait released
    assign done = cyc_en && (state_reg == edmp_pkg::st_access) && (wait_cnt_reg == '0) && wait_f_reg; // R9 R10

    // State transitions; one access in flight serialises X and Y
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= edmp_pkg::st_idle; // R2
        end else begin
            case (state_reg)
                edmp_pkg::st_idle: begin
                    if (cyc_en && !hold_f_reg) begin
                        state_reg <= edmp_pkg::st_hold; // R12
                    end else if (take) begin
                        state_reg <= edmp_pkg::st_access; // R4
                    end
                end
                edmp_pkg::st_access: begin
                    if (done) begin
                        state_reg <= edmp_pkg::st_idle;
                    end
                end
                edmp_pkg::st_hold: begin
                    if (cyc_en && hold_f_reg) begin
                        state_reg <= edmp_pkg::st_idle; // R12
                    end
                end
                default: begin
                    state_reg <= edmp_pkg::st_idle;
                end
            endcase
        end
    end

    // Wait counter loaded at start, counted down per instruction cycle
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wait_cnt_reg <= '0;
        end else if (take) begin
            wait_cnt_reg <= wait_count_in; // R8
        end else if (cyc_en && (state_reg == edmp_pkg::st_access) && (wait_cnt_reg != '0)) begin
            wait_cnt_reg <= wait_cnt_reg - 1'b1; // R8
        end
    end

    // Access latch; address is kept after the access ends
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            addr_reg <= `EDMP_ADDR_RST; // R6
            space_reg <= `EDMP_SPACE_X;
            write_reg <= 1'b0;
            wdata_reg <= `EDMP_DATA_RST;
        end else if (take) begin
            addr_reg <= req_addr_in; // R5
            space_reg <= req_space_in; // R3
            write_reg <= req_write_in;
            wdata_reg <= req_wdata_in;
        end
    end

    // Response; read data taken from the synchronised pipeline
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= `EDMP_DATA_RST;
        end else begin
            rsp_valid_out <= done;
            if (done && !write_reg) begin
                rsp_rdata_out <= data_s3_reg; // R7
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive

    // Registered pin state avoids glitches on the strobes
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            mem_read_strobe_n_out <= 1'b1; // R15
            mem_write_strobe_n_out <= 1'b1; // R15
            bus_in_use_strobe_n_out <= 1'b1;
            bus_hold_grant_n_out <= 1'b1;
            ext_ctrl_oe_n_out <= 1'b0;
            ext_data_oe_n_out <= 1'b1;
        end else begin
            mem_read_strobe_n_out <= !((state_reg == edmp_pkg::st_access) && !done && !write_reg); // R15
            mem_write_strobe_n_out <= !((state_reg == edmp_pkg::st_access) && !done && write_reg); // R15
            bus_in_use_strobe_n_out <= !((state_reg == edmp_pkg::st_access) && !done); // R13
            bus_hold_grant_n_out <= (state_reg != edmp_pkg::st_hold); // R12
            ext_ctrl_oe_n_out <= (state_reg == edmp_pkg::st_hold); // R14
            ext_data_oe_n_out <= !((state_reg == edmp_pkg::st_access) && !done && write_reg); // R7 R14
        end
    end

    assign ext_addr_out = addr_reg; // R5 R6
    assign ext_space_out = space_reg; // R3
    assign ext_data_out = wdata_reg; // R7

endmodule
`default_nettype wire

// [edmp_port_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module edmp_port_monitor #(
    parameter int WAIT_W = 4
) (
    // Clock, reset and core side
    input wire logic clk_in, rst_in, req_valid_in, req_ready_out, rsp_valid_out,
    input wire logic [WAIT_W-1:0] wait_count_in,
    // Memory bus
    input wire logic cycle_clock_out, ext_space_out, mem_read_strobe_n_out, mem_write_strobe_n_out,
    input wire logic [15:0] ext_addr_out,
    input wire logic ext_ctrl_oe_n_out, ext_data_oe_n_out, ext_wait_n_in,
    // Arbitration
    input wire logic bus_hold_request_n_in, bus_hold_grant_n_out, bus_in_use_strobe_n_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // Take of a three-wait access with the memory ready
    wire logic take3 = req_valid_in && req_ready_out && wait_count_in == WAIT_W'(3) && ext_wait_n_in;
    ////////////////////////////////////////////////////////////
    // First edge after release still sees the reset level on both sides
    chk_clock_halves: assert property (!$past(rst_in) |-> cycle_clock_out != $past(cycle_clock_out))
        else $error("cycle clock not halved");
    chk_space_steady: assert property (!bus_in_use_strobe_n_out && $past(!bus_in_use_strobe_n_out) |->
        $stable(ext_space_out)) else $error("space changed mid access");
    chk_addr_kept: assert property (!$past(rst_in) && $changed(ext_addr_out) |->
        ##[0:1] !bus_in_use_strobe_n_out) else $error("address moved while idle");
    chk_write_data: assert property (!mem_write_strobe_n_out |->
        !ext_data_oe_n_out && mem_read_strobe_n_out) else $error("write without data");
    chk_wait_count: assert property (take3 |-> !rsp_valid_out[*8] ##[1:2] rsp_valid_out)
        else $error("wait count length wrong");
    chk_grant_cause: assert property ($changed(bus_hold_grant_n_out) |->
        bus_hold_grant_n_out == $past(bus_hold_request_n_in, 2)) else $error("grant without cause");
    chk_grant_float: assert property (!bus_hold_grant_n_out |-> ext_ctrl_oe_n_out &&
        ext_data_oe_n_out && bus_in_use_strobe_n_out && !req_ready_out) else $error("bus driven in hold");
    chk_use_strobe: assert property (bus_in_use_strobe_n_out ==
        (mem_read_strobe_n_out && mem_write_strobe_n_out)) else $error("bus strobe mismatch");
endmodule
bind edmp_port edmp_port_monitor #(.WAIT_W(WAIT_W)) u_edmp_port_monitor (.clk_in(clk_in), .rst_in(rst_in),
    .req_valid_in(req_valid_in), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
    .wait_count_in(wait_count_in), .cycle_clock_out(cycle_clock_out), .ext_space_out(ext_space_out),
    .mem_read_strobe_n_out(mem_read_strobe_n_out), .mem_write_strobe_n_out(mem_write_strobe_n_out),
    .ext_addr_out(ext_addr_out), .ext_ctrl_oe_n_out(ext_ctrl_oe_n_out), .ext_data_oe_n_out(ext_data_oe_n_out),
    .ext_wait_n_in(ext_wait_n_in), .bus_hold_request_n_in(bus_hold_request_n_in),
    .bus_hold_grant_n_out(bus_hold_grant_n_out), .bus_in_use_strobe_n_out(bus_in_use_strobe_n_out));
`default_nettype wire

// [edmp_mem_model.sv]
`timescale 1ns/100ps
`default_nettype none
module edmp_mem_model (
    // Clock and knobs
    input wire logic clk_in, want_hold_in,
    input wire logic [3:0] slow_in,
    // Memory pins
    input wire logic [15:0] addr_in, wdata_in,
    input wire logic space_in, rd_n_in, wr_n_in, wdata_oe_n_in,
    output logic [15:0] rdata_out,
    output logic wait_n_out, hold_req_n_out
);
    logic [15:0] mem [0:255];
    logic [3:0] cnt = 4'h0;
    logic idle_q = 1'b1;
    logic flip = 1'b0;
    wire logic [7:0] idx = {space_in, addr_in[6:0]};
    // Master asks by pulling low
    assign hold_req_n_out = !want_hold_in;
    assign wait_n_out = (cnt == 4'h0);
    // Idle data toggles so a stale word never passes
    assign rdata_out = rd_n_in ? {16{flip}} : mem[idx];
    // Wait run starts when a strobe falls
    always_ff @(posedge clk_in) begin
        idle_q <= rd_n_in && wr_n_in;
        flip <= ~flip;
        if (idle_q && !(rd_n_in && wr_n_in)) begin
            cnt <= slow_in;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
        if (!wr_n_in && !wdata_oe_n_in) begin
            mem[idx] <= wdata_in;
        end
    end
endmodule
`default_nettype wire

// [edmp_port_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module edmp_port_tb;
    logic clk_in = 0, rst_in = 1, valid = 0, wr = 0, sp = 0, want = 0;
    logic [15:0] addr = 0, wd = 0, xaddr, dout, rdat, mdat, bus, got;
    logic [3:0] wcnt = 0, slow = 0;
    logic ready, rsp, cyc, xsp, rd_n, wr_n, coe_n, doe_n, wait_n, hreq_n, grant_n, use_n;
    int err_count = 0, compares = 0, cycles = 0, lat;
    // Clock and hang guard
    always #10 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles > 4000) begin
            err_count++;
            results();
        end
    end
    // Data wire: port drives on writes, memory otherwise
    assign bus = doe_n ? mdat : dout;
    edmp_port u_edmp_port (.clk_in, .rst_in, .req_valid_in(valid), .req_write_in(wr), .req_space_in(sp),
        .req_addr_in(addr), .req_wdata_in(wd), .wait_count_in(wcnt), .req_ready_out(ready),
        .rsp_valid_out(rsp), .rsp_rdata_out(rdat), .cycle_clock_out(cyc), .ext_addr_out(xaddr),
        .ext_space_out(xsp), .mem_read_strobe_n_out(rd_n), .mem_write_strobe_n_out(wr_n),
        .ext_ctrl_oe_n_out(coe_n), .ext_data_in(bus), .ext_data_out(dout), .ext_data_oe_n_out(doe_n),
        .ext_wait_n_in(wait_n), .bus_hold_request_n_in(hreq_n), .bus_hold_grant_n_out(grant_n),
        .bus_in_use_strobe_n_out(use_n));
    edmp_mem_model u_edmp_mem_model (.clk_in, .want_hold_in(want), .slow_in(slow), .addr_in(xaddr),
        .wdata_in(bus), .space_in(xsp), .rd_n_in(rd_n), .wr_n_in(wr_n), .wdata_oe_n_in(doe_n),
        .rdata_out(mdat), .wait_n_out(wait_n), .hold_req_n_out(hreq_n));
    ////////////////////////////////////////////////////////////
    task automatic check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task automatic results();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Request held until taken, then latency counted to the answer
    task automatic req(input logic w, s, input logic [15:0] a, d, input logic [3:0] n);
        @(negedge clk_in);
        {valid, wr, sp, addr, wd, wcnt} = {1'b1, w, s, a, d, n};
    endtask
    task automatic finish_req();
        for (lat = 0; ready !== 1'b1 && lat < 60; lat++) @(negedge clk_in);
        @(negedge clk_in);
        valid = 0;
        for (lat = 1; rsp !== 1'b1 && lat < 80; lat++) @(negedge clk_in);
        got = rdat;
    endtask
    task automatic t_reset();
        rst_in = 1;
        repeat (5) @(negedge clk_in);
        rst_in = 0;
        check(xaddr === 16'h0000 && use_n === 1'b1 && grant_n === 1'b1, "reset state");
        check(rd_n === 1'b1 && wr_n === 1'b1, "strobes idle");
        @(negedge clk_in);
        got[0] = cyc;
        @(negedge clk_in);
        check(cyc === ~got[0], "cycle clock");
    endtask
    task automatic t_rw();
        req(1, 0, 16'h0012, 16'hA5C3, 4'h3);
        finish_req();
        check(lat == 8 || lat == 9, "wait count");
        req(1, 1, 16'h0012, 16'h5A3C, 4'h0);
        finish_req();
        check(xaddr === 16'h0012 && xsp === 1'b1, "last address");
        req(0, 0, 16'h0012, 16'h0000, 4'h3);
        finish_req();
        check(got === 16'hA5C3, "read X");
        req(0, 1, 16'h0012, 16'h0000, 4'h5);
        finish_req();
        check(got === 16'h5A3C && (lat == 12 || lat == 13), "read Y");
    endtask
    // Memory holds wait low for twelve cycles; four programmed waits outlast the wait synchroniser lag
    task automatic t_slow();
        slow = 4'hC;
        req(0, 1, 16'h0012, 16'h0000, 4'h4);
        finish_req();
        slow = 4'h0;
        check(got === 16'h5A3C && lat > 12 && lat < 40, "slow read");
    endtask
    // Request left pending while the bus is granted away
    task automatic t_hold();
        want = 1;
        repeat (12) @(negedge clk_in);
        check(grant_n === 1'b0 && coe_n === 1'b1 && use_n === 1'b1, "hold grant");
        req(0, 0, 16'h0012, 16'h0000, 4'h3);
        repeat (6) @(negedge clk_in);
        check(ready === 1'b0 && rd_n === 1'b1, "no access in hold");
        want = 0;
        finish_req();
        check(got === 16'hA5C3 && grant_n === 1'b1 && coe_n === 1'b0, "hold released");
    endtask
    initial begin
        t_reset();
        t_rw();
        t_slow();
        t_hold();
        t_reset();
        results();
    end
endmodule
`default_nettype wire
